// >>> core/vcmm_unit.sv
// Vector compare, maximum and saturating multiply-accumulate execution unit
// Functional notes
// - Decode major 0xa, registers, minor opcode
// - Byte less-than fills lane ones
// - Half less-than fills lane ones
// - Minor 0x4a byte not-equal compare
// - Minor 0x4b half not-equal compare
// - Custom slots 0xc-0xf reserved, implementation-defined
// - Minor 0x54 signed multiply-accumulate into accumulators
// - Accumulator overflow saturates, never wraps
// - Products also written to destination
// - Minor 0x55 byte lane maximum
// - Minor 0x56 half lane maximum
// - Half maximum picks larger half-word
`timescale 1ns/1ns
`default_nettype none
module vcmm_unit #(
   parameter int DATA_W = 64
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic issue_in,
   input wire logic [31:0] insn_in,
   input wire logic [DATA_W-1:0] src_first_in,
   input wire logic [DATA_W-1:0] src_second_in,
   output var vcmm_pkg::vcmm_wb_s wb_out,
   output logic custom_out,
   output logic [DATA_W-1:0] acc_lo_out,
   output logic [DATA_W-1:0] acc_hi_out
);
   import vcmm_pkg::*;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   function automatic vcmm_op_e decode(input logic [31:0] insn);
      logic [7:0] minor;
      minor = insn[MINOR_W-1:0];
      if (insn[31:MAJOR_LSB] != MAJOR_VEC) begin
         return VCMM_NONE;
      end else if (minor == OP_BYTE_LT) begin
         return VCMM_BLT;
      end else if (minor == OP_HALF_LT) begin
         return VCMM_HLT;
      end else if (minor == OP_BYTE_NE) begin
         return VCMM_BNE;
      end else if (minor == OP_HALF_NE) begin
         return VCMM_HNE;
      end else if (minor == OP_HALF_MAC) begin
         return VCMM_MAC;
      end else if (minor == OP_BYTE_MAX) begin
         return VCMM_BMAX;
      end else if (minor == OP_HALF_MAX) begin
         return VCMM_HMAX;
      end else if (insn[CUST_LSB+CUST_W-1:CUST_LSB] >= CUST_FIRST) begin
         return VCMM_CUST;
      end else begin
         return VCMM_NONE;
      end
   endfunction

   vcmm_op_e op;
   logic [REG_W-1:0] rd;
   assign op = issue_in ? decode(insn_in) : VCMM_NONE;
   assign rd = insn_in[RD_LSB+REG_W-1:RD_LSB];

   // ----------------------------------------
   // Lane logic
   // ----------------------------------------
   logic [DATA_W-1:0] b_lt, b_ne, b_max, h_lt, h_ne, h_max, h_prod;
   logic [4*ACC_W-1:0] acc, next_acc;

   genvar i;
   generate
      for (i = 0; i < BYTE_LANES; i++) begin : g_byte
         logic [7:0] a, b;
         assign a = src_first_in[8*i +: 8];
         assign b = src_second_in[8*i +: 8];
         assign b_lt[8*i +: 8] = {8{a < b}};
         assign b_ne[8*i +: 8] = {8{a != b}};
         assign b_max[8*i +: 8] = (a > b) ? a : b;
      end
      for (i = 0; i < HALF_LANES; i++) begin : g_half
         logic [15:0] a, b;
         logic [31:0] prod;
         assign a = src_first_in[16*i +: 16];
         assign b = src_second_in[16*i +: 16];
         assign h_lt[16*i +: 16] = {16{a < b}};
         assign h_ne[16*i +: 16] = {16{a != b}};
         assign h_max[16*i +: 16] = (a > b) ? a : b;
         vcmm_lane_mac u_mac (
            .a_in(a),
            .b_in(b),
            .acc_in(acc[ACC_W*i +: ACC_W]),
            .prod_out(prod),
            .sum_out(next_acc[ACC_W*i +: ACC_W])
         );
         // low half of each product to destination
         assign h_prod[16*i +: 16] = prod[15:0];
      end
   endgenerate

   // ----------------------------------------
   // Result select
   // ----------------------------------------
   logic [DATA_W-1:0] result;
   assign result = (op == VCMM_BLT) ? b_lt :
                   (op == VCMM_HLT) ? h_lt :
                   (op == VCMM_BNE) ? b_ne :
                   (op == VCMM_HNE) ? h_ne :
                   (op == VCMM_BMAX) ? b_max :
                   (op == VCMM_HMAX) ? h_max : h_prod;
   logic writes;
   assign writes = (op != VCMM_NONE) && (op != VCMM_CUST);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wb_out <= '0;
         custom_out <= 1'b0;
         acc <= '0;
      end else begin
         wb_out.valid <= writes;
         wb_out.rd <= rd;
         wb_out.data <= result;
         custom_out <= (op == VCMM_CUST);
         if (op == VCMM_MAC) begin
            acc <= next_acc;
         end
      end
   end
   assign acc_lo_out = acc[2*ACC_W-1:0];
   assign acc_hi_out = acc[4*ACC_W-1:2*ACC_W];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   logic [15:0] lane0_prod;
   assign lane0_prod = 16'(src_first_in[15:0] * src_second_in[15:0]);

   chk_byte_ne_mask: assert property (
      (op == VCMM_BNE) |=> wb_out.valid && (wb_out.data == $past(b_ne)))
      else $error("byte not-equal result wrong");
   chk_byte_lt_lane: assert property (
      (op == VCMM_BLT) && (src_first_in[7:0] < src_second_in[7:0])
      |=> wb_out.data[7:0] == 8'hff)
      else $error("byte less-than lane not set");
   chk_half_lt_lane: assert property (
      (op == VCMM_HLT) && !(src_first_in[15:0] < src_second_in[15:0])
      |=> wb_out.data[15:0] == 16'h0000)
      else $error("half less-than lane not cleared");
   chk_half_ne_lane: assert property (
      (op == VCMM_HNE) && (src_first_in[63:48] != src_second_in[63:48])
      |=> wb_out.data[63:48] == 16'hffff)
      else $error("half not-equal lane not set");
   chk_byte_max_lane: assert property (
      (op == VCMM_BMAX) |=> (wb_out.data[7:0] >= $past(src_first_in[7:0]))
      && (wb_out.data[7:0] >= $past(src_second_in[7:0])))
      else $error("byte max not larger");
   chk_half_max_lane: assert property (
      (op == VCMM_HMAX) |=> (wb_out.data[31:16] >= $past(src_first_in[31:16]))
      && (wb_out.data[31:16] >= $past(src_second_in[31:16])))
      else $error("half max not larger");
   chk_mac_acc_hold: assert property (
      (op != VCMM_MAC) |=> $stable(acc))
      else $error("accumulator changed without mac");
   chk_mac_sat_high: assert property (
      (op == VCMM_MAC) && !acc[31] && (src_first_in[15] == src_second_in[15])
      |=> !acc[31])
      else $error("accumulator wrapped past maximum");
   chk_mac_sat_low: assert property (
      (op == VCMM_MAC) && acc[31] && (src_first_in[15] != src_second_in[15])
      |=> acc[31])
      else $error("accumulator wrapped past minimum");
   chk_mac_dest_write: assert property (
      (op == VCMM_MAC) |=> wb_out.valid && (wb_out.data == $past(h_prod)))
      else $error("mac products not written");
   chk_mac_prod_lane: assert property (
      (op == VCMM_MAC) |=> wb_out.data[15:0] == $past(lane0_prod))
      else $error("mac lane zero product wrong");
   chk_custom_no_wb: assert property (
      (op == VCMM_CUST) |=> custom_out && !wb_out.valid)
      else $error("custom slot wrote back");
   chk_byte_max_pick: assert property (
      (op == VCMM_BMAX) |=> (wb_out.data[63:56] == $past(src_first_in[63:56]))
      || (wb_out.data[63:56] == $past(src_second_in[63:56])))
      else $error("byte max not an operand");
   chk_half_max_pick: assert property (
      (op == VCMM_HMAX) |=> (wb_out.data[31:16] == $past(src_first_in[31:16]))
      || (wb_out.data[31:16] == $past(src_second_in[31:16])))
      else $error("half max not an operand");
   chk_byte_ne_match: assert property (
      (op == VCMM_BNE) && (src_first_in[15:8] == src_second_in[15:8])
      |=> wb_out.data[15:8] == 8'h00)
      else $error("byte not-equal lane not cleared");
   chk_none_quiet: assert property (
      (op == VCMM_NONE) |=> !wb_out.valid && !custom_out)
      else $error("unrecognised instruction had effect");
   chk_wb_dest_reg: assert property (
      (op != VCMM_NONE) && (op != VCMM_CUST) |=> wb_out.rd == $past(rd))
      else $error("writeback register wrong");

   cov_mac: cover property ((op == VCMM_MAC) ##1 (op == VCMM_MAC));
   cov_bne: cover property (op == VCMM_BNE);
   cov_hmax: cover property (op == VCMM_HMAX);
   cov_cust: cover property (op == VCMM_CUST);
   cov_sat: cover property ((op == VCMM_MAC) && (acc[31:0] == ACC_MAX));
endmodule
`default_nettype wire

// >>> core/vcmm_pkg.sv
// Package with opcode fields and types for the vector compare, max and multiply-accumulate unit
package vcmm_pkg;
   localparam int XLEN = 64;
   localparam int INSN_W = 32;
   localparam logic [5:0] MAJOR_VEC = 6'h0a;
   localparam int MAJOR_LSB = 26;
   localparam int RD_LSB = 21;
   localparam int RA_LSB = 16;
   localparam int RB_LSB = 11;
   localparam int RSV_LSB = 8;
   localparam int REG_W = 5;
   localparam int MINOR_W = 8;
   localparam logic [7:0] OP_BYTE_LT = 8'h48;
   localparam logic [7:0] OP_HALF_LT = 8'h49;
   localparam logic [7:0] OP_BYTE_NE = 8'h4a;
   localparam logic [7:0] OP_HALF_NE = 8'h4b;
   localparam logic [7:0] OP_HALF_MAC = 8'h54;
   localparam logic [7:0] OP_BYTE_MAX = 8'h55;
   localparam logic [7:0] OP_HALF_MAX = 8'h56;
   localparam int CUST_LSB = 4;
   localparam int CUST_W = 4;
   localparam logic [3:0] CUST_FIRST = 4'hc;
   localparam int BYTE_LANES = 8;
   localparam int HALF_LANES = 4;
   localparam int ACC_W = 32;
   localparam logic [31:0] ACC_MAX = 32'h7fffffff;
   localparam logic [31:0] ACC_MIN = 32'h80000000;

   typedef enum logic [3:0] {
      VCMM_NONE, VCMM_BLT, VCMM_HLT, VCMM_BNE, VCMM_HNE,
      VCMM_MAC, VCMM_BMAX, VCMM_HMAX, VCMM_CUST
   } vcmm_op_e;

   typedef struct packed {
      logic valid;
      logic [REG_W-1:0] rd;
      logic [XLEN-1:0] data;
   } vcmm_wb_s;
endpackage

// >>> core/vcmm_lane_mac.sv
// One saturating half-word multiply-accumulate lane
`timescale 1ns/1ns
`default_nettype none
module vcmm_lane_mac (
   input wire logic [15:0] a_in,
   input wire logic [15:0] b_in,
   input wire logic [31:0] acc_in,
   output logic [31:0] prod_out,
   output logic [31:0] sum_out
);
   import vcmm_pkg::*;
   logic signed [31:0] prod;
   logic signed [32:0] wide;
   logic ovf_hi;
   logic ovf_lo;
   assign prod = $signed(a_in) * $signed(b_in);
   assign wide = {acc_in[31], acc_in} + {prod[31], prod};
   assign ovf_hi = (wide[32] == 1'b0) && (wide[31] == 1'b1);
   assign ovf_lo = (wide[32] == 1'b1) && (wide[31] == 1'b0);
   assign prod_out = prod;
   assign sum_out = ovf_hi ? ACC_MAX : (ovf_lo ? ACC_MIN : wide[31:0]);
endmodule
`default_nettype wire

// >>> bench/vcmm_unit_bench.sv
// Self-checking testbench for the vector compare, maximum and multiply-accumulate unit
`timescale 1ns/1ns
`default_nettype none
module vcmm_unit_bench;
   import vcmm_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic issue_in = 1'b0;
   logic [31:0] insn_in = 32'h0;
   logic [63:0] sa = 64'h0;
   logic [63:0] sb = 64'h0;
   vcmm_wb_s wb;
   logic cust;
   logic [63:0] alo;
   logic [63:0] ahi;
   int n_errors = 0;
   int n_compared = 0;
   logic [63:0] seed = 64'h3;
   logic [63:0] r;
   logic signed [31:0] acc [4];
   logic [7:0] ops [7] = '{OP_BYTE_LT, OP_HALF_LT, OP_BYTE_NE, OP_HALF_NE, OP_HALF_MAC,
      OP_BYTE_MAX, OP_HALF_MAX};

   vcmm_unit #(.DATA_W(64)) u_dut (.clk_in(clk_in), .rst_in(rst_in), .issue_in(issue_in),
      .insn_in(insn_in), .src_first_in(sa), .src_second_in(sb), .wb_out(wb),
      .custom_out(cust), .acc_lo_out(alo), .acc_hi_out(ahi));

   always #50 clk_in = ~clk_in;

   // ---------------------------------
   // Helpers
   // ---------------------------------
   function logic [63:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 7;
      seed ^= seed << 17;
      return seed;
   endfunction

   task chk(input logic c, input string m);
      n_compared++;
      if (c !== 1'b1) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask

   task end_sim();
      if (n_errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task run(input logic [5:0] mj, input logic [7:0] mn, input logic [63:0] a, b);
      logic [63:0] d;
      logic v;
      logic cu;
      logic [4:0] rd;
      logic signed [31:0] p;
      logic signed [32:0] s;
      r = rnd();
      rd = r[4:0];
      d = 64'h0;
      v = (mj == MAJOR_VEC);
      if (v) begin
         case (mn)
            OP_BYTE_LT: for (int i = 0; i < 8; i++) d[8*i+:8] = {8{a[8*i+:8] < b[8*i+:8]}};
            OP_HALF_LT: for (int i = 0; i < 4; i++) d[16*i+:16] = {16{a[16*i+:16] < b[16*i+:16]}};
            OP_BYTE_NE: for (int i = 0; i < 8; i++) d[8*i+:8] = {8{a[8*i+:8] != b[8*i+:8]}};
            OP_HALF_NE: for (int i = 0; i < 4; i++) d[16*i+:16] = {16{a[16*i+:16] != b[16*i+:16]}};
            OP_BYTE_MAX: for (int i = 0; i < 8; i++)
               d[8*i+:8] = (a[8*i+:8] > b[8*i+:8]) ? a[8*i+:8] : b[8*i+:8];
            OP_HALF_MAX: for (int i = 0; i < 4; i++)
               d[16*i+:16] = (a[16*i+:16] > b[16*i+:16]) ? a[16*i+:16] : b[16*i+:16];
            OP_HALF_MAC: for (int i = 0; i < 4; i++) begin
               p = $signed(a[16*i+:16]) * $signed(b[16*i+:16]);
               d[16*i+:16] = p[15:0];
               s = $signed({acc[i][31], acc[i]}) + $signed({p[31], p});
               acc[i] = (s[32] != s[31]) ? (s[32] ? ACC_MIN : ACC_MAX) : s[31:0];
            end
            default: v = 1'b0;
         endcase
      end
      cu = (mj == MAJOR_VEC) && !v && (mn[7:4] >= 4'hc);
      @(posedge clk_in);
      issue_in <= 1'b1;
      insn_in <= {mj, rd, 5'h3, 5'h4, 3'h0, mn};
      sa <= a;
      sb <= b;
      @(posedge clk_in);
      issue_in <= 1'b0;
      @(negedge clk_in);
      chk(wb.valid === v, "writeback valid");
      if (v) chk(wb.rd === rd && wb.data === d, "writeback data");
      chk(cust === cu, "custom flag");
      chk(alo === {acc[1], acc[0]} && ahi === {acc[3], acc[2]}, "accumulators");
   endtask

   // ---------------------------------
   // Main sequence
   // ---------------------------------
   initial begin
      for (int i = 0; i < 4; i++) acc[i] = 32'sh0;
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      for (int k = 0; k < 7; k++) begin
         run(MAJOR_VEC, ops[k], 64'h0, 64'h0);
         run(MAJOR_VEC, ops[k], 64'hff00_7f80_0001_fffe, 64'h00ff_807f_0001_ffff);
      end
      repeat (4) run(MAJOR_VEC, OP_HALF_MAC, {4{16'h8000}}, {4{16'h8000}});
      repeat (7) run(MAJOR_VEC, OP_HALF_MAC, {4{16'h8000}}, {4{16'h7fff}});
      for (int c = 12; c < 16; c++) begin
         r = rnd();
         run(MAJOR_VEC, {c[3:0], r[3:0]}, r, ~r);
      end
      run(6'h0b, OP_BYTE_MAX, rnd(), rnd());
      run(MAJOR_VEC, 8'h40, rnd(), rnd());
      repeat (300) begin
         r = rnd();
         run(MAJOR_VEC, ops[r[5:0] % 7], rnd(), rnd());
      end
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      for (int i = 0; i < 4; i++) acc[i] = 32'sh0;
      @(negedge clk_in);
      chk(alo === 64'h0 && ahi === 64'h0 && wb.valid === 1'b0, "reset state");
      run(MAJOR_VEC, OP_HALF_MAC, rnd(), rnd());
      end_sim();
   end

   initial begin
      #2000000;
      n_errors++;
      end_sim();
   end
endmodule
`default_nettype wire
